// ===== hdl/lf_wakeup_receiver_control.sv
// Control logic of the low-frequency wake-up receiver: registers, power-up and continuous-on sequencing.
//
// What this block does
// - Continuous interval code keeps receiver powered and listening until a processed signal or, with toggle set, an on-time end.
// - Continuous mode: after a processed signal, stop and restart after 2-3 slow periods.
// - Continuous mode with toggle set: stop at on-time end, invert carrier mode, restart.
// - Trim values, once written, stay unchanged until the next MCU reset.
// - Eight memory-map locations decode data, control and status registers.
// - Enable starts power-up at next slow rising edge; one full slow cycle powers up.
// - After power-up, a 64 us auto-zero runs, then receiver is ready.
// - Enable low means standby, high means active; active disables port B GPIO.
// - Writing 1 to soft reset starts it; bit self-clears and reads zero.
// - Carrier mode 0 decodes data; 1 detects carrier and wakes MCU if enabled.
// - Page select picks paged registers, not the two control words; reset clears it.
// - ID select: none, 8-bit low, 16-bit both, 8-bit either; reset clears it.
// - Threshold select 01 low, 10 high; applies to carrier detect path only.
// - Interval code 0000 is continuous; reset loads 0110.
`timescale 1ns/10ps
module lf_wakeup_receiver_control #(
    parameter int AZ_CYCLES = lf_wake_pkg::AZ_CYCLES_DEF
) (
    // Clock and reset.
    input  wire logic                    sys_clk,
    input  wire logic                    nrst,
    // Slow timebase oscillator level, synchronous to sys_clk.
    input  wire logic                    slow_timebase_oscillator,
    // MCU register port.
    input  wire logic [2:0]              cpu_addr,
    input  wire logic                    cpu_wr,
    input  wire logic                    cpu_rd,
    input  wire logic [7:0]              cpu_wdata,
    output logic      [7:0]              cpu_rdata,
    // Receiver front-end events.
    input  wire lf_wake_pkg::rx_event_t  rx_evt,
    // Front-end control.
    output logic                         rx_powered,
    output logic                         rx_autozero,
    output logic                         rx_ready,
    output logic                         carrier_mode,
    output logic [1:0]                   id_mode,
    output logic [1:0]                   detect_threshold,
    output logic [7:0]                   wake_id_low,
    output logic [7:0]                   wake_id_high,
    output logic [15:0]                  trim_word,
    output logic                         portb_gpio_disable,
    output logic                         wake_request
);
    import lf_wake_pkg::*;

    main_ctl_t             ctl_reg, ctl_next;
    logic [3:0]            sample_interval_field_reg, sample_interval_field_next;
    logic                  mode_toggle_bit_reg, mode_toggle_bit_next;
    logic [7:0]            id_low_reg, id_low_next, id_high_reg, id_high_next;
    logic [7:0]            trim0_reg, trim0_next, trim1_reg, trim1_next;
    logic                  trim0_lock_reg, trim0_lock_next, trim1_lock_reg, trim1_lock_next;
    logic [1:0]            receiver_status_reg, receiver_status_next;
    logic [1:0]            irq_en_reg, irq_en_next;
    logic [7:0]            data_reg, data_next;
    logic [7:0]            rdata_reg, rdata_next;
    rx_state_t             state_reg, state_next;
    logic [AZ_CNT_W-1:0]   az_cnt_reg, az_cnt_next;
    logic [1:0]            gap_cnt_reg, gap_cnt_next;
    logic                  lfo_prev_reg;
    logic                  lfo_rise;
    logic                  soft_rst;
    logic                  continuous;

    function automatic logic sel(input logic [2:0] a, input logic [2:0] want);
        return a == want;
    endfunction

    assign lfo_rise   = slow_timebase_oscillator & ~lfo_prev_reg;
    assign soft_rst   = cpu_wr & sel(cpu_addr, ADDR_MAIN_CTL) & cpu_wdata[6];
    assign continuous = (sample_interval_field_reg == SAMPLE_CONT);

    // Register file and event flags.
    always_comb begin
        ctl_next                   = ctl_reg;
        sample_interval_field_next = sample_interval_field_reg;
        mode_toggle_bit_next       = mode_toggle_bit_reg;
        id_low_next                = id_low_reg;
        id_high_next               = id_high_reg;
        trim0_next                 = trim0_reg;
        trim1_next                 = trim1_reg;
        trim0_lock_next            = trim0_lock_reg;
        trim1_lock_next            = trim1_lock_reg;
        receiver_status_next       = receiver_status_reg;
        irq_en_next                = irq_en_reg;
        data_next                  = data_reg;
        rdata_next                 = rdata_reg;
        if (cpu_wr) begin
            unique case (cpu_addr)
                ADDR_MAIN_CTL: begin
                    ctl_next                = main_ctl_t'(cpu_wdata);
                    ctl_next.soft_reset_bit = 1'b0;
                end
                ADDR_SAMPLE: begin
                    sample_interval_field_next = cpu_wdata[SAMPLE_LSB +: 4];
                    mode_toggle_bit_next       = cpu_wdata[TOGGLE_BIT];
                end
                ADDR_PAGED_A: begin
                    if (!ctl_reg.register_page_select) begin
                        id_low_next = cpu_wdata;
                    end else if (!trim0_lock_reg) begin
                        trim0_next      = cpu_wdata;
                        trim0_lock_next = 1'b1;
                    end
                end
                ADDR_PAGED_B: begin
                    if (!ctl_reg.register_page_select) begin
                        id_high_next = cpu_wdata;
                    end else if (!trim1_lock_reg) begin
                        trim1_next      = cpu_wdata;
                        trim1_lock_next = 1'b1;
                    end
                end
                ADDR_STATUS: receiver_status_next = receiver_status_reg & ~cpu_wdata[1:0];
                ADDR_IRQ_EN: irq_en_next = cpu_wdata[1:0];
                default: ;
            endcase
        end
        if (soft_rst) begin
            ctl_next                   = MAIN_CTL_RST;
            sample_interval_field_next = SAMPLE_RST;
            mode_toggle_bit_next       = 1'b0;
            receiver_status_next       = 2'h0;
        end
        // Hardware sets win over a clear in the same cycle, so no event is lost.
        if (state_reg == ST_LISTEN && ctl_reg.carrier_only_select && rx_evt.carrier_seen) begin
            receiver_status_next[ST_CARRIER] = 1'b1;
        end
        if (state_reg == ST_LISTEN && !ctl_reg.carrier_only_select && rx_evt.byte_valid) begin
            receiver_status_next[ST_DATA] = 1'b1;
            data_next                     = rx_evt.byte_data;
        end
        // Continuous mode with the toggle bit set toggles carrier mode at each on-time end that has no processed signal.
        if (state_reg == ST_LISTEN && continuous && mode_toggle_bit_reg && rx_evt.on_time_end
            && !rx_evt.sig_done && !soft_rst) begin
            ctl_next.carrier_only_select = ~ctl_reg.carrier_only_select;
        end
        if (cpu_rd) begin
            unique case (cpu_addr)
                ADDR_MAIN_CTL: rdata_next = ctl_reg;
                ADDR_SAMPLE:   rdata_next = {3'h0, mode_toggle_bit_reg, sample_interval_field_reg};
                ADDR_PAGED_A:  rdata_next = ctl_reg.register_page_select ? trim0_reg : id_low_reg;
                ADDR_PAGED_B:  rdata_next = ctl_reg.register_page_select ? trim1_reg : id_high_reg;
                ADDR_STATUS:   rdata_next = {6'h0, receiver_status_reg};
                ADDR_IRQ_EN:   rdata_next = {6'h0, irq_en_reg};
                ADDR_DATA:     rdata_next = data_reg;
                ADDR_STATE:    rdata_next = {5'h0, state_reg};
                default:       rdata_next = BYTE_ZERO;
            endcase
        end
    end

    // Power-up, auto-zero and continuous-on sequencing.
    always_comb begin
        state_next   = state_reg;
        az_cnt_next  = az_cnt_reg;
        gap_cnt_next = gap_cnt_reg;
        unique case (state_reg)
            ST_OFF:       if (ctl_reg.receiver_enable_bit) state_next = ST_WAIT_EDGE;
            ST_WAIT_EDGE: if (lfo_rise) state_next = ST_POWERUP;
            ST_POWERUP: begin
                // The power-up cycle ends at the next rising edge, one full slow period later.
                if (lfo_rise) begin
                    state_next  = ST_AUTOZERO;
                    az_cnt_next = '0;
                end
            end
            ST_AUTOZERO: begin
                if (az_cnt_reg == AZ_CNT_W'(AZ_CYCLES - 1)) begin
                    state_next = ST_LISTEN;
                end else begin
                    az_cnt_next = az_cnt_reg + 1'b1;
                end
            end
            ST_LISTEN: begin
                // Sampled modes hold here too; their interval timing lives elsewhere.
                if (continuous && (rx_evt.sig_done || (mode_toggle_bit_reg && rx_evt.on_time_end))) begin
                    state_next   = ST_GAP;
                    gap_cnt_next = '0;
                end
            end
            ST_GAP: begin
                // Three rising edges give an idle gap of two to three slow periods.
                if (lfo_rise) begin
                    if (gap_cnt_reg == GAP_LFO_EDGES - 2'h1) begin
                        state_next = ST_POWERUP;
                    end else begin
                        gap_cnt_next = gap_cnt_reg + 2'h1;
                    end
                end
            end
        endcase
        if (!ctl_reg.receiver_enable_bit || soft_rst) begin
            state_next = ST_OFF;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctl_reg                   <= MAIN_CTL_RST;
            sample_interval_field_reg <= SAMPLE_RST;
            mode_toggle_bit_reg       <= 1'b0;
            id_low_reg                <= BYTE_ZERO;
            id_high_reg               <= BYTE_ZERO;
            trim0_reg                 <= BYTE_ZERO;
            trim1_reg                 <= BYTE_ZERO;
            trim0_lock_reg            <= 1'b0;
            trim1_lock_reg            <= 1'b0;
            receiver_status_reg       <= 2'h0;
            irq_en_reg                <= 2'h0;
            data_reg                  <= BYTE_ZERO;
            rdata_reg                 <= BYTE_ZERO;
            state_reg                 <= ST_OFF;
            az_cnt_reg                <= '0;
            gap_cnt_reg               <= 2'h0;
            lfo_prev_reg              <= 1'b0;
        end else begin
            ctl_reg                   <= ctl_next;
            sample_interval_field_reg <= sample_interval_field_next;
            mode_toggle_bit_reg       <= mode_toggle_bit_next;
            id_low_reg                <= id_low_next;
            id_high_reg               <= id_high_next;
            trim0_reg                 <= trim0_next;
            trim1_reg                 <= trim1_next;
            trim0_lock_reg            <= trim0_lock_next;
            trim1_lock_reg            <= trim1_lock_next;
            receiver_status_reg       <= receiver_status_next;
            irq_en_reg                <= irq_en_next;
            data_reg                  <= data_next;
            rdata_reg                 <= rdata_next;
            state_reg                 <= state_next;
            az_cnt_reg                <= az_cnt_next;
            gap_cnt_reg               <= gap_cnt_next;
            lfo_prev_reg              <= slow_timebase_oscillator;
        end
    end

    assign cpu_rdata          = rdata_reg;
    assign rx_powered         = (state_reg != ST_OFF) && (state_reg != ST_WAIT_EDGE) && (state_reg != ST_GAP);
    assign rx_autozero        = (state_reg == ST_AUTOZERO);
    assign rx_ready           = (state_reg == ST_LISTEN);
    assign carrier_mode       = ctl_reg.carrier_only_select;
    assign id_mode            = ctl_reg.wake_id_select;
    assign detect_threshold   = ctl_reg.threshold_select;
    assign wake_id_low        = id_low_reg;
    assign wake_id_high       = id_high_reg;
    assign trim_word          = {trim1_reg, trim0_reg};
    assign portb_gpio_disable = ctl_reg.receiver_enable_bit;
    assign wake_request       = |(receiver_status_reg & irq_en_reg);

    property p_srst_reads_zero;
        @(posedge sys_clk) disable iff (!nrst)
        (cpu_rd && cpu_addr == ADDR_MAIN_CTL) |=> !cpu_rdata[6];
    endproperty
    a_srst_reads_zero: assert property (p_srst_reads_zero) else $error("Soft reset bit read back as one.");

    sequence s_edge_in_wait;
        state_reg == ST_WAIT_EDGE && lfo_rise && ctl_reg.receiver_enable_bit && !soft_rst;
    endsequence
    property p_powerup_on_edge;
        @(posedge sys_clk) disable iff (!nrst)
        s_edge_in_wait |=> state_reg == ST_POWERUP ##0 rx_powered;
    endproperty
    a_powerup_on_edge: assert property (p_powerup_on_edge) else $error("Power-up did not start on slow edge.");

    property p_autozero_done;
        @(posedge sys_clk) disable iff (!nrst)
        (rx_autozero && az_cnt_reg == AZ_CNT_W'(AZ_CYCLES - 1) && ctl_reg.receiver_enable_bit && !soft_rst)
            |=> rx_ready && !rx_autozero;
    endproperty
    a_autozero_done: assert property (p_autozero_done) else $error("Receiver not ready after auto-zero.");

    property p_autozero_not_early;
        @(posedge sys_clk) disable iff (!nrst)
        $rose(rx_ready) |-> $past(az_cnt_reg) == AZ_CNT_W'(AZ_CYCLES - 1);
    endproperty
    a_autozero_not_early: assert property (p_autozero_not_early) else $error("Ready before auto-zero ended.");

    property p_standby;
        @(posedge sys_clk) disable iff (!nrst)
        !ctl_reg.receiver_enable_bit |=> state_reg == ST_OFF && !rx_powered;
    endproperty
    a_standby: assert property (p_standby) else $error("Receiver active with enable clear.");

    property p_continuous_stays;
        @(posedge sys_clk) disable iff (!nrst)
        (rx_ready && continuous && ctl_reg.receiver_enable_bit && !rx_evt.sig_done && !rx_evt.on_time_end
            && !soft_rst) |=> rx_ready;
    endproperty
    a_continuous_stays: assert property (p_continuous_stays) else $error("Continuous receiver left listening.");

    property p_restart_gap;
        @(posedge sys_clk) disable iff (!nrst)
        (rx_ready && continuous && rx_evt.sig_done && ctl_reg.receiver_enable_bit && !soft_rst)
            |=> state_reg == ST_GAP && !rx_powered;
    endproperty
    a_restart_gap: assert property (p_restart_gap) else $error("No stop after processed signal.");

    property p_gap_end;
        @(posedge sys_clk) disable iff (!nrst)
        (state_reg == ST_GAP && lfo_rise && gap_cnt_reg == 2'h2 && ctl_reg.receiver_enable_bit && !soft_rst)
            |=> state_reg == ST_POWERUP;
    endproperty
    a_gap_end: assert property (p_gap_end) else $error("Restart did not follow the third slow edge.");

    property p_toggle_mode;
        @(posedge sys_clk) disable iff (!nrst)
        (rx_ready && continuous && mode_toggle_bit_reg && rx_evt.on_time_end && !rx_evt.sig_done
            && !soft_rst && !cpu_wr) |=> carrier_mode != $past(carrier_mode) && state_reg == ST_GAP;
    endproperty
    a_toggle_mode: assert property (p_toggle_mode) else $error("Carrier mode not toggled at on-time end.");

    property p_trim_held;
        @(posedge sys_clk) disable iff (!nrst)
        (trim0_lock_reg && trim1_lock_reg) |=> $stable(trim_word);
    endproperty
    a_trim_held: assert property (p_trim_held) else $error("Trim value changed after being written.");

    property p_soft_reset_fields;
        @(posedge sys_clk) disable iff (!nrst)
        soft_rst |=> !ctl_reg.register_page_select && id_mode == ID_NONE
            && sample_interval_field_reg == SAMPLE_RST && state_reg == ST_OFF;
    endproperty
    a_soft_reset_fields: assert property (p_soft_reset_fields) else $error("Soft reset left fields set.");

endmodule

// ===== hdl/lf_wake_pkg.sv
// Constants, register map and types for the low-frequency wake-up receiver control.
package lf_wake_pkg;

    // Timing: system clock and auto-zero time.
    localparam int CLK_PERIOD_NS = 10;
    localparam int AUTOZERO_US   = 64;
    localparam int AZ_CYCLES_DEF = (AUTOZERO_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int AZ_CNT_W      = 16;
    localparam logic [1:0] GAP_LFO_EDGES = 2'h3;

    // Register index within the eight-word window.
    localparam logic [2:0] ADDR_MAIN_CTL  = 3'h0;
    localparam logic [2:0] ADDR_SAMPLE    = 3'h1;
    localparam logic [2:0] ADDR_PAGED_A   = 3'h2;
    localparam logic [2:0] ADDR_PAGED_B   = 3'h3;
    localparam logic [2:0] ADDR_STATUS    = 3'h4;
    localparam logic [2:0] ADDR_IRQ_EN    = 3'h5;
    localparam logic [2:0] ADDR_DATA      = 3'h6;
    localparam logic [2:0] ADDR_STATE     = 3'h7;

    // Field positions outside the main control word.
    localparam int SAMPLE_LSB   = 0;
    localparam int TOGGLE_BIT   = 4;
    localparam int ST_CARRIER   = 0;
    localparam int ST_DATA      = 1;
    localparam int IE_CARRIER   = 0;
    localparam int IE_DATA      = 1;

    // Reset values and field codes.
    localparam logic [3:0] SAMPLE_RST     = 4'h6;
    localparam logic [3:0] SAMPLE_CONT    = 4'h0;
    localparam logic [7:0] BYTE_ZERO      = 8'h00;
    localparam logic [1:0] ID_NONE        = 2'h0;
    localparam logic [1:0] THR_LOW        = 2'h1;
    localparam logic [1:0] THR_HIGH       = 2'h2;

    // Main control word, laid out exactly as the register bits 7 down to 0.
    typedef struct packed {
        logic       receiver_enable_bit;
        logic       soft_reset_bit;
        logic       carrier_only_select;
        logic       register_page_select;
        logic [1:0] wake_id_select;
        logic [1:0] threshold_select;
    } main_ctl_t;

    localparam main_ctl_t MAIN_CTL_RST = '{1'b0, 1'b0, 1'b0, 1'b0, ID_NONE, 2'h0};

    // Events coming from the analog front end and decoder.
    typedef struct packed {
        logic       sig_done;
        logic       carrier_seen;
        logic       byte_valid;
        logic [7:0] byte_data;
        logic       on_time_end;
    } rx_event_t;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_WAIT_EDGE,
        ST_POWERUP,
        ST_AUTOZERO,
        ST_LISTEN,
        ST_GAP
    } rx_state_t;

endpackage

// ===== tb/lf_source_model.sv
// Behavioural stand-in for the base-station signal as seen through the front-end decoder.
`timescale 1ns/10ps
module lf_source_model (
    // Clock.
    input  wire logic                   sys_clk,
    // Bench commands: one-hot kind {done, carrier, byte, on-time end}, byte value, strobe.
    input  wire logic                   go,
    input  wire logic [3:0]             kind,
    input  wire logic [7:0]             val,
    // Events toward the receiver control.
    output lf_wake_pkg::rx_event_t      rx_evt
);
    import lf_wake_pkg::*;

    // Outside a strobe the data lines show the inverse, so a stale byte never looks valid.
    always_ff @(posedge sys_clk) begin
        if (go) begin
            rx_evt <= '{kind[3], kind[2], kind[1], val, kind[0]};
        end else begin
            rx_evt <= '{1'b0, 1'b0, 1'b0, ~val, 1'b0};
        end
    end
endmodule

// ===== tb/lf_wakeup_receiver_control_tb.sv
// Self-checking bench for the low-frequency wake-up receiver control.
`timescale 1ns/10ps
module lf_wakeup_receiver_control_tb;
    import lf_wake_pkg::*;
    // Auto-zero is shortened; the slow oscillator runs at a 20-cycle period.
    localparam int AZ_SIM = 8;
    localparam int HALF   = 10;
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        osc = 1'b0;
    logic [2:0]  cpu_addr = 3'h0;
    logic        cpu_wr = 1'b0;
    logic        cpu_rd = 1'b0;
    logic [7:0]  cpu_wdata = 8'h00;
    logic [7:0]  cpu_rdata;
    rx_event_t   rx_evt;
    logic        go = 1'b0;
    logic [3:0]  kind = 4'h0;
    logic [7:0]  val = 8'h00;
    logic        rx_powered, rx_autozero, rx_ready, carrier_mode, portb_gpio_disable, wake_request;
    logic [1:0]  id_mode, detect_threshold;
    logic [7:0]  wake_id_low, wake_id_high;
    logic [15:0] trim_word;
    int          errors = 0;
    int          total_checks = 0;
    int          slow_cnt = 0;
    int          n;

    lf_wakeup_receiver_control #(.AZ_CYCLES(AZ_SIM)) i_lf_wakeup_receiver_control (
        .sys_clk(sys_clk), .nrst(nrst), .slow_timebase_oscillator(osc), .cpu_addr(cpu_addr),
        .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
        .rx_evt(rx_evt), .rx_powered(rx_powered), .rx_autozero(rx_autozero), .rx_ready(rx_ready),
        .carrier_mode(carrier_mode), .id_mode(id_mode), .detect_threshold(detect_threshold),
        .wake_id_low(wake_id_low), .wake_id_high(wake_id_high), .trim_word(trim_word),
        .portb_gpio_disable(portb_gpio_disable), .wake_request(wake_request));
    lf_source_model i_lf_source_model (.sys_clk(sys_clk), .go(go), .kind(kind), .val(val), .rx_evt(rx_evt));

    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        #1;
        slow_cnt = (slow_cnt == HALF - 1) ? 0 : slow_cnt + 1;
        if (slow_cnt == 0) osc = ~osc;
    end

    task automatic close_out();
        if (errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        idle(1);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_wr = 1'b1;
        idle(1);
        cpu_wr = 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        idle(1);
        cpu_addr = a;
        cpu_rd = 1'b1;
        idle(1);
        cpu_rd = 1'b0;
        idle(1);
        check(cpu_rdata, exp);
    endtask
    task automatic send(input logic [3:0] k, input logic [7:0] v);
        idle(1);
        kind = k;
        val = v;
        go = 1'b1;
        idle(1);
        go = 1'b0;
        idle(1);
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: return rx_ready;
            1: return rx_powered;
            default: return rx_autozero;
        endcase
    endfunction
    task automatic wait_on(input int s);
        for (int i = 0; i < 2000; i++) begin
            if (pick(s) === 1'b1) return;
            idle(1);
        end
        errors++;
        close_out();
    endtask
    task automatic count_while(input int s, input logic lvl, output int c);
        c = 0;
        while (pick(s) === lvl && c < 2000) begin
            c++;
            idle(1);
        end
        if (c == 2000) begin
            errors++;
            close_out();
        end
    endtask

    task automatic t_reset();
        rd(3'h0, 8'h00);
        rd(3'h1, 8'h06);
        rd(3'h7, 8'h00);
        check(portb_gpio_disable, 1'b0);
    endtask
    task automatic t_config();
        for (int c = 0; c < 4; c++) begin
            wr(3'h0, {4'h2, c[1:0], c[1:0]});
            idle(1);
            check(id_mode, c[1:0]);
            check(detect_threshold, c[1:0]);
            check(carrier_mode, 1'b1);
        end
        wr(3'h0, 8'h10);
        wr(3'h2, 8'h34);
        wr(3'h3, 8'h12);
        wr(3'h2, 8'hff);
        idle(1);
        check(trim_word, 16'h1234);
        rd(3'h1, 8'h06);
        wr(3'h0, 8'h00);
        wr(3'h2, 8'ha5);
        idle(1);
        check(wake_id_low, 8'ha5);
        rd(3'h2, 8'ha5);
        wr(3'h3, 8'h5b);
        idle(1);
        check(wake_id_high, 8'h5b);
    endtask
    task automatic t_enable();
        wr(3'h1, 8'h00);
        wr(3'h0, 8'h85);
        idle(1);
        check(portb_gpio_disable, 1'b1);
        wait_on(1);
        count_while(2, 1'b0, n);
        check(16'(n), 16'd20);
        count_while(2, 1'b1, n);
        check(16'(n), 16'(AZ_SIM));
        check(rx_ready, 1'b1);
        idle(100);
        check(rx_ready, 1'b1);
        rd(3'h7, 8'h04);
    endtask
    task automatic t_data();
        wr(3'h4, 8'h03);
        wr(3'h5, 8'h03);
        idle(1);
        check(wake_request, 1'b0);
        send(4'b0010, 8'h5a);
        check(wake_request, 1'b1);
        rd(3'h6, 8'h5a);
        send(4'b0100, 8'h00);
        rd(3'h4, 8'h02);
        wr(3'h4, 8'h02);
        idle(1);
        check(wake_request, 1'b0);
    endtask
    task automatic t_gap();
        send(4'b1000, 8'h00);
        check(rx_ready, 1'b0);
        count_while(1, 1'b0, n);
        check(n >= 40 && n <= 60, 1'b1);
        wait_on(0);
    endtask
    task automatic t_toggle();
        wr(3'h0, 8'h00);
        idle(40);
        check(rx_powered, 1'b0);
        wr(3'h1, 8'h10);
        wr(3'h0, 8'h80);
        wait_on(0);
        send(4'b0001, 8'h00);
        idle(1);
        check(rx_ready, 1'b0);
        check(carrier_mode, 1'b1);
        wait_on(0);
        send(4'b0100, 8'h00);
        rd(3'h4, 8'h01);
        check(wake_request, 1'b1);
    endtask
    task automatic t_soft();
        wr(3'h0, 8'h50);
        idle(1);
        check(rx_powered, 1'b0);
        rd(3'h0, 8'h00);
        rd(3'h1, 8'h06);
        rd(3'h4, 8'h00);
        check(trim_word, 16'h1234);
        wr(3'h1, 8'h00);
        idle(40);
        wr(3'h0, 8'h80);
        wait_on(0);
        rd(3'h7, 8'h04);
        // A full reset must free the trim words for a fresh write.
        nrst = 1'b0;
        idle(2);
        nrst = 1'b1;
        rd(3'h7, 8'h00);
        wr(3'h0, 8'h10);
        wr(3'h2, 8'h77);
        idle(1);
        check(trim_word, 16'h0077);
    endtask

    initial begin
        idle(5);
        nrst = 1'b1;
        t_reset();
        t_config();
        t_enable();
        t_data();
        t_gap();
        t_toggle();
        t_soft();
        close_out();
    end
endmodule
